/* File: pkg/keypad_cfg.svh */
// Offsets, field positions, reset values and counts of the keypad interrupt unit.
// Assumes a 25 MHz system clock and an APB master with 32-bit data.
// -----------------------------------------------------------------------------
// Behaviour
// RQ1 - Status bits seven to four read zero.
// RQ2 - Pending flag shows the latched request.
// RQ3 - Writing acknowledge one clears request; reads zero.
// RQ4 - Mask bit set blocks request to CPU.
// RQ5 - Sensitivity one: edges and levels; zero: edges.
// RQ6 - Four pin enable bits select source pins.
// RQ7 - Reset clears every pin enable bit.
// RQ8 - Unit runs in wait; unmasked request wakes.
// RQ9 - Unit runs in stop; unmasked request wakes.
// RQ10 - Latch when enabled pin falls, all high before.
// RQ11 - Level mode clears after acknowledge and pins high.
// RQ12 - Pending flag ignores the mask bit.
// RQ13 - Enabled pin gets pullup and forced input.
// RQ14 - CPU request is latch and not mask.
// RQ15 - Pins synchronised; stop mode low sets asynchronously.
// -----------------------------------------------------------------------------
`ifndef KEYPAD_CFG_SVH
`define KEYPAD_CFG_SVH

// -----------------------------------------------------------------------------
// Register offsets
// -----------------------------------------------------------------------------
`define KP_ADDR_W            12
`define KP_OFS_STATUS_CTRL   12'h000
`define KP_OFS_PIN_ENABLE    12'h004
`define KP_OFS_EVENT_STATUS  12'h008
`define KP_OFS_EVENT_ENABLE  12'h00C

// -----------------------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------------------
`define KP_BIT_PENDING       3
`define KP_BIT_ACK           2
`define KP_BIT_MASK          1
`define KP_BIT_SENS          0
`define KP_EVT_LATCHED       0
`define KP_EVT_CLEARED       1
`define KP_PINS              4
`define KP_EVENTS            2
`define KP_SYNC_W            5

// -----------------------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------------------
`define KP_RST_PIN_ENABLE    4'h0
`define KP_RST_EVENT_ENABLE  2'h0

`endif

/* File: pkg/keypad_pkg.sv */
// State types of the keypad interrupt unit.
// Assumes keypad_cfg.svh is included before this package is compiled.
`include "keypad_cfg.svh"

package keypad_pkg;

  typedef logic [`KP_PINS-1:0]   pin_vec_t;
  typedef logic [`KP_EVENTS-1:0] evt_vec_t;

  typedef struct packed {
    logic [`KP_SYNC_W-1:0] stage1;
    logic [`KP_SYNC_W-1:0] stage2;
  } sync_state_s;

  typedef struct packed {
    logic wake;
  } wake_state_s;

  typedef struct packed {
    logic        sens;
    logic        mask;
    pin_vec_t    pin_en;
    logic        latch;
    logic        ack_seen;
    logic        prev_low;
    logic        prev_wake;
    logic        cpu_req;
    evt_vec_t    evt;
    evt_vec_t    evt_en;
    logic        irq;
    logic        pready;
    logic        pslverr;
    logic [7:0]  prdata;
  } unit_state_s;

endpackage : keypad_pkg

/* File: logic/input_sync.sv */
// Two-stage synchroniser for the port pins and the stop wake flag.
// Assumes inputs are asynchronous to clk_sys.
`include "keypad_cfg.svh"
module input_sync (
  input  wire logic                  clk_sys,
  input  wire logic                  rst_n,
  input  wire logic [`KP_SYNC_W-1:0] async_in,
  output logic      [`KP_SYNC_W-1:0] sync_out
);
  import keypad_pkg::*;

  sync_state_s state_reg;
  sync_state_s state_next;

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb begin
    state_next.stage1 = async_in;
    state_next.stage2 = state_reg.stage1;
  end

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign sync_out = state_reg.stage2;

endmodule : input_sync

/* File: logic/stop_wake_latch.sv */
// Wake flag that an enabled low pin sets without a clock during stop mode while the mask bit is clear.
// Assumes the main unit returns wake_taken once it has seen the flag.
`include "keypad_cfg.svh"
module stop_wake_latch (
  input  wire keypad_pkg::pin_vec_t pins_raw,
  input  wire logic                clk_sys,
  input  wire logic                rst_n,
  input  wire logic                stop_mode,
  input  wire keypad_pkg::pin_vec_t pin_en,
  input  wire logic                request_mask,
  input  wire logic                wake_taken,
  output logic                     wake
);
  import keypad_pkg::*;

  wake_state_s state_reg;
  wake_state_s state_next;
  logic        set_now;

  // ---------------------------------------------------------------------------
  // Asynchronous set condition
  // ---------------------------------------------------------------------------
  assign set_now = stop_mode & ~request_mask & (|(~pins_raw & pin_en)); // RQ9 RQ15

  always_comb begin
    state_next.wake = state_reg.wake & ~wake_taken;
  end

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n or posedge set_now) begin
    if (!rst_n) begin
      state_reg <= '0;
    end else if (set_now) begin
      state_reg.wake <= 1'b1; // RQ15
    end else begin
      state_reg <= state_next;
    end
  end

  assign wake = state_reg.wake;

endmodule : stop_wake_latch

/* File: logic/keypad_interrupt_unit.sv */
// Keypad interrupt unit: four port pins, request latch, APB registers, interrupt.
// Assumes an APB master on clk_sys and asynchronous key switches on the pins.
`include "keypad_cfg.svh"
module keypad_interrupt_unit (
  input  wire logic                   clk_sys,
  input  wire logic                   rst_n,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [`KP_ADDR_W-1:0]  paddr,
  input  wire logic [31:0]            pwdata,
  input  wire logic [3:0]             pstrb,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire keypad_pkg::pin_vec_t   port_a_pin,
  input  wire logic                   vector_fetch,
  input  wire logic                   stop_mode,
  output logic                        keypad_cpu_request,
  output logic                        stop_wake,
  output keypad_pkg::pin_vec_t        pin_pullup_en,
  output keypad_pkg::pin_vec_t        pin_force_input,
  output logic                        irq
);
  import keypad_pkg::*;

  unit_state_s              state_reg;
  unit_state_s              state_next;
  logic [`KP_SYNC_W-1:0]    sync_bits;
  pin_vec_t                 pins_sync;
  logic                     wake_sync;
  logic                     wake_flag;

  // ---------------------------------------------------------------------------
  // Input synchronisation and stop wake
  // ---------------------------------------------------------------------------
  input_sync u_sync (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .async_in ({wake_flag, port_a_pin}), // RQ15
    .sync_out (sync_bits)
  );

  assign pins_sync = sync_bits[`KP_PINS-1:0];
  assign wake_sync = sync_bits[`KP_PINS];

  stop_wake_latch u_wake (
    .pins_raw     (port_a_pin),
    .clk_sys      (clk_sys),
    .rst_n        (rst_n),
    .stop_mode    (stop_mode),
    .pin_en       (state_reg.pin_en),
    .request_mask (state_reg.mask),
    .wake_taken   (wake_sync),
    .wake         (wake_flag)
  );

  // ---------------------------------------------------------------------------
  // Register read value
  // ---------------------------------------------------------------------------
  function automatic logic [7:0] read_value(input logic [`KP_ADDR_W-1:0] addr,
                                            input unit_state_s s);
    logic [7:0] v;
    v = 8'h00;
    case (addr)
      `KP_OFS_STATUS_CTRL: begin
        v[`KP_BIT_PENDING] = s.latch; // RQ2 RQ12
        v[`KP_BIT_ACK]     = 1'b0;    // RQ3
        v[`KP_BIT_MASK]    = s.mask;
        v[`KP_BIT_SENS]    = s.sens;  // RQ1
      end
      `KP_OFS_PIN_ENABLE:   v[`KP_PINS-1:0]   = s.pin_en;
      `KP_OFS_EVENT_STATUS: v[`KP_EVENTS-1:0] = s.evt;
      `KP_OFS_EVENT_ENABLE: v[`KP_EVENTS-1:0] = s.evt_en;
      default:              v = 8'h00;
    endcase
    return v;
  endfunction : read_value

  function automatic logic addr_mapped(input logic [`KP_ADDR_W-1:0] addr);
    return (addr == `KP_OFS_STATUS_CTRL) || (addr == `KP_OFS_PIN_ENABLE) ||
           (addr == `KP_OFS_EVENT_STATUS) || (addr == `KP_OFS_EVENT_ENABLE);
  endfunction : addr_mapped

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb begin
    logic     setup;
    logic     done;
    logic     wr;
    logic     ack;
    logic     any_low;
    logic     edge_set;
    logic     wake_set;
    logic     clear_ok;
    evt_vec_t evt_set;

    state_next = state_reg;
    setup      = psel & ~penable;
    done       = psel & penable & state_reg.pready;
    wr         = done & pwrite & pstrb[0] & ~state_reg.pslverr;

    // Bus answer is prepared during setup and offered in the first access cycle.
    state_next.pready = setup;
    if (setup) begin
      state_next.pslverr = ~addr_mapped(paddr);
      state_next.prdata  = pwrite ? 8'h00 : read_value(paddr, state_reg);
    end else if (done) begin
      state_next.pslverr = 1'b0;
      state_next.prdata  = 8'h00;
    end

    // Control writes.
    if (wr && paddr == `KP_OFS_STATUS_CTRL) begin
      state_next.mask = pwdata[`KP_BIT_MASK]; // RQ4
      state_next.sens = pwdata[`KP_BIT_SENS]; // RQ5
    end
    if (wr && paddr == `KP_OFS_PIN_ENABLE) begin
      state_next.pin_en = pwdata[`KP_PINS-1:0]; // RQ6
    end
    if (wr && paddr == `KP_OFS_EVENT_ENABLE) begin
      state_next.evt_en = pwdata[`KP_EVENTS-1:0];
    end

    // Request latch.
    ack      = vector_fetch | (wr && paddr == `KP_OFS_STATUS_CTRL && pwdata[`KP_BIT_ACK]); // RQ3
    any_low  = |(~pins_sync & state_reg.pin_en);
    edge_set = any_low & ~state_reg.prev_low; // RQ10
    wake_set = wake_sync & ~state_reg.prev_wake; // RQ9
    state_next.prev_low  = any_low;
    state_next.prev_wake = wake_sync;
    clear_ok = state_reg.sens ? ((ack | state_reg.ack_seen) & ~any_low) : ack; // RQ11
    state_next.latch    = edge_set | wake_set | (state_reg.latch & ~clear_ok); // RQ10 RQ11
    state_next.ack_seen = state_reg.sens & state_next.latch & ~edge_set &
                          (state_reg.ack_seen | ack); // RQ11

    // CPU request, also the wait-mode wake source.
    state_next.cpu_req = state_next.latch & ~state_next.mask; // RQ14 RQ8

    // Sticky events; a new event wins over the write-one clear.
    evt_set = '0;
    evt_set[`KP_EVT_LATCHED] = state_next.latch & ~state_reg.latch;
    evt_set[`KP_EVT_CLEARED] = state_reg.latch & ~state_next.latch;
    if (wr && paddr == `KP_OFS_EVENT_STATUS) begin
      state_next.evt = state_reg.evt & ~pwdata[`KP_EVENTS-1:0];
    end
    state_next.evt = state_next.evt | evt_set;
    state_next.irq = |(state_next.evt & state_next.evt_en);
  end

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg        <= '0;
      state_reg.pin_en <= `KP_RST_PIN_ENABLE; // RQ7
      state_reg.evt_en <= `KP_RST_EVENT_ENABLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign prdata             = {24'h000000, state_reg.prdata}; // RQ1
  assign pready             = state_reg.pready;
  assign pslverr            = state_reg.pslverr;
  assign keypad_cpu_request = state_reg.cpu_req; // RQ4 RQ14
  assign stop_wake          = wake_flag; // RQ9
  assign pin_pullup_en      = state_reg.pin_en; // RQ13
  assign pin_force_input    = state_reg.pin_en; // RQ13
  assign irq                = state_reg.irq;

endmodule : keypad_interrupt_unit

/* File: testbench/keypad_chk.sv */
// Checker of the keypad interrupt unit ports.
// Assumes it is bound into keypad_interrupt_unit.
`include "keypad_cfg.svh"
module keypad_chk (
  input wire logic                  clk_sys,
  input wire logic                  rst_n,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [`KP_ADDR_W-1:0] paddr,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire logic                  stop_mode,
  input wire logic                  keypad_cpu_request,
  input wire logic                  stop_wake,
  input wire keypad_pkg::pin_vec_t  pin_pullup_en,
  input wire keypad_pkg::pin_vec_t  pin_force_input
);
  timeunit 1ns;
  timeprecision 1ps;
  import keypad_pkg::*;
  logic rd_sc;
  logic wr_pe;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  assign rd_sc = pready && !pwrite && paddr == `KP_OFS_STATUS_CTRL;
  assign wr_pe = psel && penable && pready && pwrite && paddr == `KP_OFS_PIN_ENABLE;
  AST_UPPER_ZERO: assert property (
    rd_sc |-> prdata[31:4] == 28'h0) else $error("status upper bits set");
  AST_ACK_READ: assert property (
    rd_sc |-> !prdata[`KP_BIT_ACK]) else $error("acknowledge reads one");
  AST_MASK_BLOCK: assert property (
    rd_sc && prdata[`KP_BIT_MASK] |-> !keypad_cpu_request) else $error("masked request");
  AST_PEND_REQ: assert property (
    rd_sc && !prdata[`KP_BIT_MASK] |-> prdata[`KP_BIT_PENDING] == keypad_cpu_request)
    else $error("pending and request differ");
  AST_PIN_IO: assert property (
    pin_pullup_en == pin_force_input) else $error("pullup and input differ");
  AST_PIN_WRITE: assert property (
    $changed(pin_pullup_en) |-> $past(wr_pe) || $past(wr_pe, 2)) else $error("enable moved");
  AST_RESET_CLEAR: assert property (
    $rose(rst_n) |-> pin_pullup_en == 4'h0 && !keypad_cpu_request) else $error("not cleared");
  AST_STOP_WAKE: assert property (
    $rose(stop_wake) |-> stop_mode || $past(stop_mode)) else $error("wake outside stop");
  AST_APB_READY: assert property (
    psel && !penable |=> pready ##1 !pready) else $error("pready timing");
  cover property (rd_sc && prdata[`KP_BIT_PENDING]);
  cover property ($rose(stop_wake));
  cover property ($rose(keypad_cpu_request));
endmodule : keypad_chk

bind keypad_interrupt_unit keypad_chk keypad_chk_i (.clk_sys, .rst_n, .psel, .penable, .pwrite,
  .paddr, .prdata, .pready, .stop_mode, .keypad_cpu_request, .stop_wake, .pin_pullup_en,
  .pin_force_input);

/* File: testbench/key_switch_model.sv */
// Key switches on the four port pins.
// Assumes the unit switches pullups on through pin_pullup_en.
`include "keypad_cfg.svh"
module key_switch_model (
  input  wire logic                 clk_sys,
  input  wire keypad_pkg::pin_vec_t pin_pullup_en,
  input  wire keypad_pkg::pin_vec_t press,
  output keypad_pkg::pin_vec_t      port_a_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  import keypad_pkg::*;
  pin_vec_t flt;
  initial flt = 4'hA;
  always @(posedge clk_sys) flt <= ~flt;
  // A pressed key pulls low; a free pin floats unless its pullup is on.
  always_comb begin
    for (int i = 0; i < `KP_PINS; i++) begin
      port_a_pin[i] = press[i] ? 1'b0 : (pin_pullup_en[i] ? 1'b1 : flt[i]);
    end
  end
endmodule : key_switch_model

/* File: testbench/keypad_interrupt_unit_tb.sv */
// Self-checking bench of the keypad interrupt unit.
// Assumes the key switch model and the bound checker.
`include "keypad_cfg.svh"
module keypad_interrupt_unit_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import keypad_pkg::*;
  localparam logic [11:0] ST = `KP_OFS_STATUS_CTRL;
  localparam logic [11:0] PE = `KP_OFS_PIN_ENABLE;
  localparam logic [11:0] ES = `KP_OFS_EVENT_STATUS;
  localparam logic [11:0] EE = `KP_OFS_EVENT_ENABLE;
  logic clk_sys, rst_n, psel, penable, pwrite, vector_fetch, stop_mode, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, keypad_cpu_request, stop_wake, irq;
  pin_vec_t port_a_pin, pin_pullup_en, pin_force_input, press;
  int miscompares, num_checks;

  keypad_interrupt_unit keypad_interrupt_unit_i (.clk_sys, .rst_n, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb(4'hF), .prdata, .pready, .pslverr, .port_a_pin, .vector_fetch,
    .stop_mode, .keypad_cpu_request, .stop_wake, .pin_pullup_en, .pin_force_input, .irq);
  key_switch_model key_switch_model_i (.clk_sys, .pin_pullup_en, .press, .port_a_pin);

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chkb(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask : chkb

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    penable <= 1'b0;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    if (n >= 20) miscompares++;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rdc

  task automatic keys(input pin_vec_t k);
    press <= k;
    repeat (6) @(posedge clk_sys);
  endtask : keys

  task automatic t_reset;
    rdc(ST, 32'h0);
    rdc(PE, 32'h0);
    rdc(12'h010, 32'h0);
    chkb(err, 1'b1);
    wr(ST, 32'hFF);
    rdc(ST, 32'h3);
    wr(PE, 32'h2);
    keys(4'h2);
    wr(ST, 32'h2);
    rdc(ST, 32'hA);
    chkb(keypad_cpu_request, 1'b0);
    keys(4'h0);
    wr(ST, 32'h6);
    rdc(ST, 32'h2);
  endtask : t_reset

  task automatic t_edge;
    wr(PE, 32'h3);
    keys(4'h0);
    chk(32'(pin_pullup_en), 32'h3);
    wr(ST, 32'h6);
    wr(ST, 32'h0);
    keys(4'h4);
    rdc(ST, 32'h0);
    keys(4'h1);
    rdc(ST, 32'h8);
    chkb(keypad_cpu_request, 1'b1);
    press <= 4'h3;
    wr(ST, 32'h4);
    keys(4'h3);
    rdc(ST, 32'h0);
    keys(4'h0);
  endtask : t_edge

  task automatic t_level;
    wr(ST, 32'h1);
    keys(4'h1);
    rdc(ST, 32'h9);
    vector_fetch <= 1'b1;
    @(posedge clk_sys);
    vector_fetch <= 1'b0;
    keys(4'h1);
    rdc(ST, 32'h9);
    keys(4'h0);
    rdc(ST, 32'h1);
    keys(4'h2);
    keys(4'h0);
    rdc(ST, 32'h9);
    wr(ST, 32'h5);
    rdc(ST, 32'h1);
    wr(ST, 32'h0);
  endtask : t_level

  task automatic t_irq_stop;
    wr(ES, 32'h3);
    wr(EE, 32'h1);
    chkb(irq, 1'b0);
    stop_mode <= 1'b1;
    keys(4'h1);
    chkb(stop_wake, 1'b1);
    stop_mode <= 1'b0;
    keys(4'h1);
    rdc(ST, 32'h8);
    chkb(keypad_cpu_request, 1'b1);
    chkb(irq, 1'b1);
    rdc(ES, 32'h1);
    wr(EE, 32'h0);
    chkb(irq, 1'b0);
    wr(EE, 32'h1);
    wr(ES, 32'h1);
    chkb(irq, 1'b0);
    keys(4'h0);
    wr(ST, 32'h4);
    rdc(ES, 32'h2);
  endtask : t_irq_stop

  initial begin
    rst_n = 1'b0;
    {psel, penable, pwrite, vector_fetch, stop_mode} = 5'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    press = 4'h0;
    miscompares = 0;
    num_checks = 0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    t_reset();
    t_edge();
    t_level();
    t_irq_stop();
    finish_test();
  end

  initial begin
    #200us;
    miscompares++;
    finish_test();
  end
endmodule : keypad_interrupt_unit_tb
